// file: common/ios_pkg.sv
`default_nettype none
package ios_pkg;

  // Bus clock
  localparam int CLK_PERIOD_NS = 25;

  // Nominal source frequencies in kHz
  localparam logic [16:0] HF_NOMINAL_KHZ = 17'h03e80;
  localparam logic [16:0] MF_NOMINAL_KHZ = 17'h001f4;
  localparam logic [16:0] LF_NOMINAL_KHZ = 17'h0001f;
  localparam logic [1:0]  MULT_SHIFT     = 2'h2;

  // Settling times in ns and their cycle counts
  localparam int HF_RUN_NS    = 2000;
  localparam int HF_LOCK_NS   = 4000;
  localparam int HF_STABLE_NS = 8000;
  localparam int MF_RUN_NS    = 2000;
  localparam int LF_RUN_NS    = 1000;
  localparam int CNT_W        = 10;
  localparam logic [CNT_W-1:0] HF_RUN_CYC    = CNT_W'((HF_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HF_LOCK_CYC   = CNT_W'((HF_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HF_STABLE_CYC = CNT_W'((HF_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MF_RUN_CYC    = CNT_W'((MF_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] LF_RUN_CYC    = CNT_W'((LF_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register indices
  localparam int          ADDR_W   = 2;
  localparam logic [1:0]  REG_CTRL = 2'h0;
  localparam logic [1:0]  REG_STAT = 2'h1;
  localparam logic [1:0]  REG_TRIM = 2'h2;

  // Control register fields
  localparam int SCS_LSB     = 0;
  localparam int SCS_W       = 2;
  localparam int SCS_INT_BIT = 1;
  localparam int IRCF_LSB    = 3;
  localparam int IRCF_W      = 4;
  localparam int TRIM_W      = 6;
  localparam logic [SCS_W-1:0]  SCS_RST  = 2'h0;
  localparam logic [IRCF_W-1:0] IRCF_RST = 4'h7;
  localparam logic [TRIM_W-1:0] TRIM_RST = 6'h00;

  // Frequency select codes
  localparam logic [IRCF_W-1:0] IRCF_LF     = 4'h0;
  localparam logic [IRCF_W-1:0] IRCF_MF_TOP = 4'h9;
  localparam logic [IRCF_W-1:0] IRCF_HF_TOP = 4'hf;

  // Status register bits
  localparam int ST_HF_STABLE = 0;
  localparam int ST_HF_LOCK   = 1;
  localparam int ST_HF_RUN    = 2;
  localparam int ST_MF_RUN    = 3;
  localparam int ST_LF_RUN    = 4;
  localparam int ST_PIN       = 5;

  // Configuration words
  localparam int         CFG_W          = 14;
  localparam int         CFG1_FOSC_LSB  = 0;
  localparam int         CFG1_COEN_BIT  = 11;
  localparam int         CFG2_MULT_BIT  = 8;
  localparam logic [1:0] FOSC_INTERNAL  = 2'h0;

  typedef enum logic [4:0] {
    HF_OFF    = 5'b00001,
    HF_START  = 5'b00010,
    HF_RUN    = 5'b00100,
    HF_LOCK   = 5'b01000,
    HF_STABLE = 5'b10000
  } ios_hf_state_t;

  typedef enum logic [4:0] {
    SRC_EXT     = 5'b00001,
    SRC_LF      = 5'b00010,
    SRC_MF      = 5'b00100,
    SRC_HF      = 5'b01000,
    SRC_STARTUP = 5'b10000
  } ios_src_t;

endpackage
`default_nettype wire

// file: verilog/ios_internal_osc_select.sv
// What this block does
// - Provide calibrated 16 MHz high-frequency source built from mid source and multiplier.
// - Provide calibrated 500 kHz mid-frequency source, also the high source reference.
// - Provide uncalibrated 31 kHz low-frequency source as third internal choice.
// - Config select 00 makes internal source the system clock right after reset.
// - Software may switch to internal source at run time via source select.
// - Enable high source when high frequency chosen and config 00 or select 1x.
// - Enable mid source under the same config 00 or select 1x condition.
// - High source goes through postscaler; 4-bit frequency select picks output.
// - Mid source goes through postscaler offering nine selectable frequencies.
// - Software trims high and mid source frequency via trim register.
// - Fast start-up source clocks circuits until the high source is running.
// - Status shows a ready flag while the high source runs.
// - Status shows a locked flag once high source is within 2 percent.
// - Status shows a stable flag once high source is within 0.5 percent.
// - Status shows a ready flag while the mid source runs.
// - Internal oscillator mode frees the external clock input pin for GPIO.
// - Clock-output enable config decides GPIO or clock drive on output pin.
// - Multiplier-enable config bit 8 turns the four-times multiplier on or off.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module ios_internal_osc_select
  import ios_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                ce,
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [7:0]          regWdata,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output var  logic [7:0]          regRdata,
  input  wire logic [CFG_W-1:0]    cfgWord1,
  input  wire logic [CFG_W-1:0]    cfgWord2,
  input  wire logic                extClkPin,
  output var  logic                hfOscEnable,
  output var  logic                mfOscEnable,
  output var  logic                lfOscEnable,
  output var  logic [TRIM_W-1:0]   oscTrim,
  output var  ios_src_t            sysClkSource,
  output var  logic [16:0]         sysFreqKhz,
  output var  logic                multiplierOn,
  output var  logic                extClkPinFree,
  output var  logic                clkOutPinOut,
  output var  logic                clkOutPinOe
);

  typedef struct packed {
    logic [SCS_W-1:0]  scs;
    logic [IRCF_W-1:0] ircf;
    logic [TRIM_W-1:0] trim;
    ios_hf_state_t     hfState;
    logic [CNT_W-1:0]  hfCnt;
    logic [CNT_W-1:0]  mfCnt;
    logic              mfRun;
    logic [CNT_W-1:0]  lfCnt;
    logic              lfRun;
    logic [2:0]        pinSync;
    logic              pinLevel;
    logic [7:0]        rdata;
    logic              hfEn;
    logic              mfEn;
    logic              lfEn;
    ios_src_t          src;
    logic [16:0]       freq;
    logic              mult;
    logic              pinFree;
    logic              coOut;
    logic              coOe;
  } ios_state_t;

  localparam ios_state_t ST_RST = '{
    scs:      SCS_RST,
    ircf:     IRCF_RST,
    trim:     TRIM_RST,
    hfState:  HF_OFF,
    hfCnt:    '0,
    mfCnt:    '0,
    mfRun:    1'b0,
    lfCnt:    '0,
    lfRun:    1'b0,
    pinSync:  3'h0,
    pinLevel: 1'b0,
    rdata:    8'h00,
    hfEn:     1'b0,
    mfEn:     1'b0,
    lfEn:     1'b0,
    src:      SRC_EXT,
    freq:     17'h00000,
    mult:     1'b0,
    pinFree:  1'b0,
    coOut:    1'b0,
    coOe:     1'b0
  };

  ios_state_t st_reg;
  ios_state_t st_next;

  logic              intCfg;
  logic              intSel;
  logic              hfCode;
  logic              mfCode;
  logic              hfWant;
  logic              mfWant;
  logic              lfWant;
  logic              hfRunning;
  logic [7:0]        statusWord;

  // Start-up counter shared by the mid and low sources
  function automatic logic [CNT_W:0] startStep(
    input logic             want,
    input logic             run,
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] limit
  );
    logic [CNT_W:0] res;
    res = {run, cnt};
    if (!want)
    begin
      res = '0;
    end
    else if (!run)
    begin
      if (cnt == limit - 1'b1)
      begin
        res = {1'b1, {CNT_W{1'b0}}};
      end
      else
      begin
        res = {1'b0, cnt + 1'b1};
      end
    end
    return res;
  endfunction

  always_comb
  begin
    intCfg    = cfgWord1[CFG1_FOSC_LSB +: 2] == FOSC_INTERNAL;
    intSel    = intCfg || st_reg.scs[SCS_INT_BIT];
    hfCode    = st_reg.ircf > IRCF_MF_TOP;
    mfCode    = (st_reg.ircf != IRCF_LF) && !hfCode;
    hfWant    = intSel && hfCode;
    mfWant    = intSel && (hfCode || mfCode);
    lfWant    = intSel && (st_reg.ircf == IRCF_LF);
    hfRunning = (st_reg.hfState == HF_RUN) || (st_reg.hfState == HF_LOCK)
                || (st_reg.hfState == HF_STABLE);
    statusWord               = 8'h00;
    statusWord[ST_HF_STABLE] = st_reg.hfState == HF_STABLE;
    statusWord[ST_HF_LOCK]   = (st_reg.hfState == HF_LOCK)
                               || (st_reg.hfState == HF_STABLE);
    statusWord[ST_HF_RUN]    = hfRunning;
    statusWord[ST_MF_RUN]    = st_reg.mfRun;
    statusWord[ST_LF_RUN]    = st_reg.lfRun;
    statusWord[ST_PIN]       = st_reg.pinLevel;
  end

  always_comb
  begin
    st_next = st_reg;
    if (ce)
    begin
      // Register writes
      if (regWr && regAddr == REG_CTRL)
      begin
        st_next.scs  = regWdata[SCS_LSB +: SCS_W];
        st_next.ircf = regWdata[IRCF_LSB +: IRCF_W];
      end
      if (regWr && regAddr == REG_TRIM)
      begin
        st_next.trim = regWdata[TRIM_W-1:0];
      end
      // Read data stand one cycle only
      st_next.rdata = 8'h00;
      if (regRd)
      begin
        case (regAddr)
          REG_CTRL: st_next.rdata = 8'(st_reg.scs) | (8'(st_reg.ircf) << IRCF_LSB);
          REG_STAT: st_next.rdata = statusWord;
          REG_TRIM: st_next.rdata = 8'(st_reg.trim);
          default:  st_next.rdata = 8'h00;
        endcase
      end

      // High source settling sequence
      case (st_reg.hfState)
        HF_OFF:
        begin
          st_next.hfCnt = '0;
          if (hfWant)
          begin
            st_next.hfState = HF_START;
          end
        end
        HF_START:
        begin
          st_next.hfCnt = st_reg.hfCnt + 1'b1;
          if (st_reg.hfCnt == HF_RUN_CYC - 1'b1)
          begin
            st_next.hfState = HF_RUN;
            st_next.hfCnt   = '0;
          end
        end
        HF_RUN:
        begin
          st_next.hfCnt = st_reg.hfCnt + 1'b1;
          if (st_reg.hfCnt == HF_LOCK_CYC - 1'b1)
          begin
            st_next.hfState = HF_LOCK;
            st_next.hfCnt   = '0;
          end
        end
        HF_LOCK:
        begin
          st_next.hfCnt = st_reg.hfCnt + 1'b1;
          if (st_reg.hfCnt == HF_STABLE_CYC - 1'b1)
          begin
            st_next.hfState = HF_STABLE;
            st_next.hfCnt   = '0;
          end
        end
        HF_STABLE:
        begin
          // A new trim has to settle again
          if (regWr && regAddr == REG_TRIM)
          begin
            st_next.hfState = HF_LOCK;
            st_next.hfCnt   = '0;
          end
        end
        default:
        begin
          st_next.hfState = HF_OFF;
          st_next.hfCnt   = '0;
        end
      endcase
      if (!hfWant)
      begin
        st_next.hfState = HF_OFF;
        st_next.hfCnt   = '0;
      end

      {st_next.mfRun, st_next.mfCnt} = startStep(mfWant, st_reg.mfRun, st_reg.mfCnt,
                                                 MF_RUN_CYC);
      {st_next.lfRun, st_next.lfCnt} = startStep(lfWant, st_reg.lfRun, st_reg.lfCnt,
                                                 LF_RUN_CYC);

      // Pin synchroniser, level taken once two stages agree
      st_next.pinSync = {st_reg.pinSync[1:0], extClkPin};
      if (st_reg.pinSync[1] == st_reg.pinSync[2])
      begin
        st_next.pinLevel = st_reg.pinSync[2];
      end

      // Registered outputs
      st_next.hfEn = hfWant;
      st_next.mfEn = mfWant;
      st_next.lfEn = lfWant;
      st_next.mult = hfWant && cfgWord2[CFG2_MULT_BIT];
      if (!intSel)
      begin
        st_next.src  = SRC_EXT;
        st_next.freq = 17'h00000;
      end
      else if (hfCode)
      begin
        if (hfRunning)
        begin
          st_next.src  = SRC_HF;
          st_next.freq = HF_NOMINAL_KHZ >> (IRCF_HF_TOP - st_reg.ircf);
          if (st_next.mult && st_reg.ircf == IRCF_HF_TOP)
          begin
            st_next.freq = HF_NOMINAL_KHZ << MULT_SHIFT;
          end
        end
        else
        begin
          st_next.src  = SRC_STARTUP;
          st_next.freq = 17'h00000;
        end
      end
      else if (mfCode)
      begin
        st_next.src  = SRC_MF;
        st_next.freq = MF_NOMINAL_KHZ >> (IRCF_MF_TOP - st_reg.ircf);
      end
      else
      begin
        st_next.src  = SRC_LF;
        st_next.freq = LF_NOMINAL_KHZ;
      end
      st_next.pinFree = intCfg;
      st_next.coOe    = !cfgWord1[CFG1_COEN_BIT];
      st_next.coOut   = st_next.coOe ? !st_reg.coOut : 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_reg <= ST_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign regRdata      = st_reg.rdata;
  assign hfOscEnable   = st_reg.hfEn;
  assign mfOscEnable   = st_reg.mfEn;
  assign lfOscEnable   = st_reg.lfEn;
  assign oscTrim       = st_reg.trim;
  assign sysClkSource  = st_reg.src;
  assign sysFreqKhz    = st_reg.freq;
  assign multiplierOn  = st_reg.mult;
  assign extClkPinFree = st_reg.pinFree;
  assign clkOutPinOut  = st_reg.coOut;
  assign clkOutPinOe   = st_reg.coOe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence sHfSwitchOn;
    ce && $rose(hfOscEnable);
  endsequence

  sequence sCtrlIntWrite;
    !sys_rst && ce && regWr && regAddr == REG_CTRL && regWdata[SCS_INT_BIT];
  endsequence

  a_hf_enable_cond: assert property (!sys_rst && ce |=> hfOscEnable ==
      $past((cfgWord1[CFG1_FOSC_LSB +: 2] == FOSC_INTERNAL || st_reg.scs[SCS_INT_BIT])
            && st_reg.ircf > IRCF_MF_TOP))
    else $error("high source enable mismatch");

  a_mf_follows_hf: assert property (hfOscEnable |-> mfOscEnable)
    else $error("high source on without mid source");

  a_startup_first: assert property (sHfSwitchOn |-> sysClkSource != SRC_HF)
    else $error("high source used before start-up");

  a_hf_ready_state: assert property (!sys_rst && ce && regRd && regAddr == REG_STAT |=>
      regRdata[ST_HF_RUN] == $past(hfRunning) && regRdata[ST_MF_RUN] == $past(st_reg.mfRun))
    else $error("status read mismatch");

  a_lock_needs_run: assert property (ce && $rose(st_reg.hfState == HF_LOCK)
      && $past(st_reg.hfState) == HF_RUN |-> $past(st_reg.hfCnt) == HF_LOCK_CYC - 1'b1)
    else $error("locked too early");

  a_stable_timing: assert property (ce && st_reg.hfState == HF_LOCK
      && st_reg.hfCnt == HF_STABLE_CYC - 1'b1 && hfOscEnable |=>
      st_reg.hfState == HF_STABLE || st_reg.hfState == HF_OFF)
    else $error("stable flag not reached");

  a_mf_ready_off: assert property (!mfOscEnable |-> !st_reg.mfRun)
    else $error("mid ready while disabled");

  a_run_switch: assert property (sCtrlIntWrite ##1 ce |=>
      sysClkSource != SRC_EXT)
    else $error("run-time switch to internal failed");

  a_reset_default: assert property ((!sys_rst && ce && intCfg
      && st_reg.scs == SCS_RST)[*2] |-> sysClkSource != SRC_EXT)
    else $error("internal default not used");

  a_pin_freed: assert property (!sys_rst && ce |=> extClkPinFree == $past(intCfg))
    else $error("clock input pin freeing wrong");

  a_clock_output_pin_pin: assert property (!sys_rst && ce |=>
      clkOutPinOe == !$past(cfgWord1[CFG1_COEN_BIT]) && (clkOutPinOe || !clkOutPinOut))
    else $error("clock output pin mode wrong");

  a_mult_enable: assert property (!sys_rst && ce |=> multiplierOn ==
      $past(cfgWord2[CFG2_MULT_BIT] && hfWant))
    else $error("multiplier enable mismatch");

  a_trim_write: assert property (!sys_rst && ce && regWr && regAddr == REG_TRIM |=>
      oscTrim == $past(regWdata[TRIM_W-1:0]))
    else $error("trim not stored");

endmodule
`default_nettype wire

// file: verification/test_ios_internal_osc_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_ios_internal_osc_select
  import ios_pkg::*;
;
  typedef struct packed {
    logic [1:0]  scs;
    logic [3:0]  code;
    ios_src_t    src;
    logic [16:0] freq;
    logic        hf;
  } ios_row_t;

  logic               clk;
  logic               sys_rst;
  logic               ce;
  logic [ADDR_W-1:0]  regAddr;
  logic [7:0]         regWdata;
  logic               regWr;
  logic               regRd;
  logic [7:0]         regRdata;
  logic [CFG_W-1:0]   cfgWord1;
  logic [CFG_W-1:0]   cfgWord2;
  logic               extClkPin;
  logic               hfOscEnable;
  logic               mfOscEnable;
  logic               lfOscEnable;
  logic [TRIM_W-1:0]  oscTrim;
  ios_src_t           sysClkSource;
  logic [16:0]        sysFreqKhz;
  logic               multiplierOn;
  logic               extClkPinFree;
  logic               clkOutPinOut;
  logic               clkOutPinOe;
  int                 n_fail;
  int                 comparisons;
  int                 cycles;
  logic [7:0]         d;
  logic               b;
  ios_row_t           rows [19] = '{
    '{2'h2, 4'h0, SRC_LF, 17'h0001f, 1'b0}, '{2'h2, 4'h1, SRC_MF, 17'h00001, 1'b0},
    '{2'h2, 4'h2, SRC_MF, 17'h00003, 1'b0}, '{2'h2, 4'h3, SRC_MF, 17'h00007, 1'b0},
    '{2'h2, 4'h4, SRC_MF, 17'h0000f, 1'b0}, '{2'h2, 4'h5, SRC_MF, 17'h0001f, 1'b0},
    '{2'h2, 4'h6, SRC_MF, 17'h0003e, 1'b0}, '{2'h2, 4'h7, SRC_MF, 17'h0007d, 1'b0},
    '{2'h2, 4'h8, SRC_MF, 17'h000fa, 1'b0}, '{2'h2, 4'h9, SRC_MF, 17'h001f4, 1'b0},
    '{2'h2, 4'ha, SRC_HF, 17'h001f4, 1'b1}, '{2'h2, 4'hb, SRC_HF, 17'h003e8, 1'b1},
    '{2'h2, 4'hc, SRC_HF, 17'h007d0, 1'b1}, '{2'h2, 4'hd, SRC_HF, 17'h00fa0, 1'b1},
    '{2'h2, 4'he, SRC_HF, 17'h01f40, 1'b1}, '{2'h2, 4'hf, SRC_HF, 17'h03e80, 1'b1},
    '{2'h3, 4'hf, SRC_HF, 17'h03e80, 1'b1}, '{2'h1, 4'hf, SRC_EXT, 17'h00000, 1'b0},
    '{2'h0, 4'hf, SRC_EXT, 17'h00000, 1'b0}};

  ios_internal_osc_select i_dut (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .ce            (ce),
    .regAddr       (regAddr),
    .regWdata      (regWdata),
    .regWr         (regWr),
    .regRd         (regRd),
    .regRdata      (regRdata),
    .cfgWord1      (cfgWord1),
    .cfgWord2      (cfgWord2),
    .extClkPin     (extClkPin),
    .hfOscEnable   (hfOscEnable),
    .mfOscEnable   (mfOscEnable),
    .lfOscEnable   (lfOscEnable),
    .oscTrim       (oscTrim),
    .sysClkSource  (sysClkSource),
    .sysFreqKhz    (sysFreqKhz),
    .multiplierOn  (multiplierOn),
    .extClkPinFree (extClkPinFree),
    .clkOutPinOut  (clkOutPinOut),
    .clkOutPinOe   (clkOutPinOe)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [16:0] e, input logic [16:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      n_fail++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    v = regRdata;
  endtask

  task automatic do_reset(input logic [CFG_W-1:0] c1, input logic [CFG_W-1:0] c2);
    @(posedge clk);
    sys_rst  <= 1'b1;
    cfgWord1 <= c1;
    cfgWord2 <= c2;
    cyc(20);
    chk(17'(SRC_EXT), 17'(sysClkSource));
    chk(17'h0, 17'(hfOscEnable));
    @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end

  initial
  begin
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    sys_rst = 1'b1;
    ce = 1'b1;
    regAddr = 2'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    cfgWord1 = 14'h0000;
    cfgWord2 = 14'h0000;
    extClkPin = 1'b0;
    // Config selects internal source, clock-out pin drives
    do_reset(14'h0000, 14'h0000);
    cyc(100);
    chk(17'(SRC_MF), 17'(sysClkSource));
    chk(17'h0007d, sysFreqKhz);
    chk(17'h1, 17'(mfOscEnable));
    chk(17'h1, 17'(extClkPinFree));
    chk(17'h1, 17'(clkOutPinOe));
    b = clkOutPinOut;
    cyc(1);
    chk(17'(!b), 17'(clkOutPinOut));
    rd(REG_CTRL, d);
    chk(17'h38, 17'(d));
    rd(REG_TRIM, d);
    chk(17'h0, 17'(d));
    // External source from config, clock-out pin released
    do_reset(14'h0803, 14'h0000);
    cyc(5);
    chk(17'h0, 17'(extClkPinFree));
    chk(17'h0, 17'(clkOutPinOe));
    chk(17'h0, 17'(clkOutPinOut));
    chk(17'(SRC_EXT), 17'(sysClkSource));
    foreach (rows[i])
    begin
      wr(REG_CTRL, {1'b0, rows[i].code, 1'b0, rows[i].scs});
      cyc(120);
      chk(17'(rows[i].src), 17'(sysClkSource));
      chk(rows[i].freq, sysFreqKhz);
      chk(17'(rows[i].hf), 17'(hfOscEnable));
      if (rows[i].code == 4'h0)
        chk(17'h1, 17'(lfOscEnable));
      else
        chk(17'(rows[i].src !== SRC_EXT), 17'(mfOscEnable));
      chk(17'(rows[i].src == SRC_LF), 17'(lfOscEnable));
      rd(REG_CTRL, d);
      chk(17'({1'b0, rows[i].code, 1'b0, rows[i].scs}), 17'(d));
    end
    // Settling sequence of the high source from off
    wr(REG_CTRL, 8'h7a);
    extClkPin <= 1'b1;
    cyc(60);
    rd(REG_STAT, d);
    chk(17'h0, 17'(d[ST_HF_RUN]));
    chk(17'(SRC_STARTUP), 17'(sysClkSource));
    cyc(40);
    rd(REG_STAT, d);
    chk(17'h1, 17'(d[ST_HF_RUN]));
    chk(17'h0, 17'(d[ST_HF_LOCK]));
    chk(17'(SRC_HF), 17'(sysClkSource));
    cyc(100);
    rd(REG_STAT, d);
    chk(17'h0, 17'(d[ST_HF_LOCK]));
    cyc(50);
    rd(REG_STAT, d);
    chk(17'h1, 17'(d[ST_HF_LOCK]));
    chk(17'h0, 17'(d[ST_HF_STABLE]));
    cyc(330);
    rd(REG_STAT, d);
    chk(17'h2f, 17'(d & 8'h2f));
    // Trim while stable drops back to locked
    wr(REG_TRIM, 8'h15);
    cyc(3);
    chk(17'h15, 17'(oscTrim));
    rd(REG_STAT, d);
    chk(17'h06, 17'(d & 8'h07));
    rd(REG_TRIM, d);
    chk(17'h15, 17'(d));
    // Strobes ignored while the clock enable is low, and at the unused address
    @(posedge clk);
    ce <= 1'b0;
    wr(REG_CTRL, 8'h00);
    ce <= 1'b1;
    rd(REG_CTRL, d);
    chk(17'h7a, 17'(d));
    wr(2'h3, 8'hff);
    rd(2'h3, d);
    chk(17'h0, 17'(d));
    // Multiplier enabled by config word 2
    do_reset(14'h0803, 14'h0100);
    wr(REG_CTRL, 8'h7a);
    cyc(120);
    chk(17'h1, 17'(multiplierOn));
    chk(17'h0fa00, sysFreqKhz);
    wr(REG_CTRL, 8'h4a);
    cyc(120);
    chk(17'h0, 17'(multiplierOn));
    complete_run();
  end
endmodule
`default_nettype wire
